// ===== rtl/vol_pkg.sv
// Types shared by the volume and mute control block.
`default_nettype none
package vol_pkg;
   typedef logic [8:0] qgain_t;
   typedef logic [23:0] timer_t;
   typedef enum logic [1:0] {
      ZC_NOW = 2'b00,
      ZC_DISCARD = 2'b01,
      ZC_FLUSH = 2'b10,
      ZC_RSVD = 2'b11
   } zc_mode_t;
   typedef struct packed {
      logic [7:0] trim;
      logic [7:0] mute;
      logic [5:0] cfg1;
      logic [4:0] cfg2;
      logic [1:0] pin_sync;
      logic [7:0] zc_s1;
      logic [7:0] zc_s2;
      qgain_t [7:0] last_tgt;
      qgain_t [7:0] applied;
      qgain_t [7:0] pend;
      logic [7:0] pend_v;
      timer_t [7:0] timer;
      logic [7:0] mute_eff;
      logic [7:0] rdata;
   } state_t;
endpackage
`default_nettype wire

// ===== rtl/volume_mute_config_regs.sv
// Trim, mute, pin-mute, pair-link and zero-crossing timing logic for an eight-channel volume stage.
// Function
// RULE1: Set trim bit adds a quarter decibel.
// RULE2: Trim changes obey zero-crossing mode and time-out.
// RULE3: Any code valid; gain clamped to analog span.
// RULE4: Gain is half-step code plus trim quarter.
// RULE5: Mute bit n mutes channel n plus one.
// RULE6: Pin enable gates the external mute pin.
// RULE7: Polarity bit selects the pin's muting level.
// RULE8: Linked pair follows the odd channel's settings.
// RULE9: Link bits three..zero tie channels eight..two.
// RULE10: Unlinked pair channels are controlled independently.
// RULE11: Time-out field bits 4:2, reset selects 18 ms.
// RULE12: Time-out codes map to 5..50 ms.
// RULE13: Mode: immediate, discard superseded, or flush superseded.
// RULE14: Half-step code is twice dB plus 210.
// RULE15: Time-out counts clocks, restarts on new change.
`include "volume_mute_regs.svh"
`default_nettype none
module volume_mute_config_regs import vol_pkg::*; #(
   parameter int unsigned CYC_PER_MS = `NS_PER_MS / `CLK_PERIOD_NS
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic [7:0][7:0] vol_code_in,
   input wire logic [7:0] zero_cross_in,
   input wire logic mute_pin_in,
   output logic [7:0] rdata_out,
   output logic [7:0][8:0] gain_out,
   output logic [7:0] mute_out
);
   state_t q;
   state_t d;
   zc_mode_t mode;
   timer_t limit;
   qgain_t [7:0] tgt;
   logic [7:0] chg;
   logic [7:0] msel;
   logic pin_act;

   // Cycles of the selected time-out, less one, since the count starts at zero.
   function automatic timer_t to_limit(input logic [2:0] sel);
      int unsigned ms;
      ms = 0;
      unique case (sel)
         3'h0: ms = `TO_MS_0;
         3'h1: ms = `TO_MS_1;
         3'h2: ms = `TO_MS_2;
         3'h3: ms = `TO_MS_3;
         3'h4: ms = `TO_MS_4;
         3'h5: ms = `TO_MS_5;
         3'h6: ms = `TO_MS_6;
         3'h7: ms = `TO_MS_7;
      endcase
      return timer_t'(ms * CYC_PER_MS - 1); // RULE12 RULE15
   endfunction

   assign mode = zc_mode_t'(q.cfg2[`CFG2_MODE_MSB:0]);
   assign limit = to_limit(q.cfg2[`CFG2_TO_MSB:`CFG2_TO_LSB]); // RULE11
   assign pin_act = q.cfg1[`CFG1_PIN_EN] && (q.pin_sync[1] == q.cfg1[`CFG1_PIN_POL]); // RULE6 RULE7

   for (genvar i = 0; i < 8; i++) begin : g_ch
      localparam int P = i - (i % 2);
      logic link;
      qgain_t raw;
      // An even channel of a linked pair takes its odd partner's code, trim and mute.
      assign link = (i % 2 == 1) && q.cfg1[i / 2]; // RULE8 RULE9 RULE10
      // The quarter-step code is the half-step volume code with the trim bit appended.
      assign raw = link ? {vol_code_in[P], q.trim[P]} : {vol_code_in[i], q.trim[i]}; // RULE1 RULE4 RULE14
      assign tgt[i] = (raw > `GAIN_MAX) ? `GAIN_MAX : ((raw < `GAIN_MIN) ? `GAIN_MIN : raw); // RULE3
      assign msel[i] = link ? q.mute[P] : q.mute[i]; // RULE5 RULE8
      assign chg[i] = tgt[i] != q.last_tgt[i];
   end

   always_comb begin
      d = q;
      d.pin_sync = {q.pin_sync[0], mute_pin_in};
      d.zc_s1 = zero_cross_in;
      d.zc_s2 = q.zc_s1;
      for (int i = 0; i < 8; i++) begin
         d.mute_eff[i] = msel[i] | pin_act; // RULE5 RULE6
         d.last_tgt[i] = tgt[i];
         if (q.pend_v[i]) begin
            d.timer[i] = q.timer[i] + 24'h000001;
            // A pending change lands on a zero crossing, on time-out, or at once in immediate or reserved mode.
            if (q.zc_s2[i] || q.timer[i] >= limit || mode == ZC_NOW || mode == ZC_RSVD) begin // RULE13 RULE15
               d.applied[i] = q.pend[i];
               d.pend_v[i] = 1'b0;
            end
         end
         if (chg[i]) begin
            if (mode == ZC_NOW || mode == ZC_RSVD) begin
               d.applied[i] = tgt[i]; // RULE13
               d.pend_v[i] = 1'b0;
            end else begin
               if (q.pend_v[i] && mode == ZC_FLUSH) begin
                  d.applied[i] = q.pend[i]; // RULE13
               end
               d.pend[i] = tgt[i]; // RULE2 RULE13
               d.pend_v[i] = 1'b1;
               d.timer[i] = '0; // RULE15
            end
         end
      end
      if (wr_en_in) begin
         case (addr_in)
            `ADDR_TRIM: d.trim = wdata_in;
            `ADDR_MUTE: d.mute = wdata_in;
            `ADDR_CFG1: d.cfg1 = wdata_in[5:0];
            `ADDR_CFG2: d.cfg2 = wdata_in[4:0];
            default: d.trim = q.trim;
         endcase
      end
      if (rd_en_in) begin
         case (addr_in)
            `ADDR_TRIM: d.rdata = q.trim;
            `ADDR_MUTE: d.rdata = q.mute;
            `ADDR_CFG1: d.rdata = {2'h0, q.cfg1};
            `ADDR_CFG2: d.rdata = {3'h0, q.cfg2};
            default: d.rdata = 8'h00;
         endcase
      end
      if (!rst_n_in) begin
         d = '0;
         // The synchronisers keep sampling through reset, so no false pin mute follows its release.
         d.pin_sync = {q.pin_sync[0], mute_pin_in};
         d.zc_s1 = zero_cross_in;
         d.zc_s2 = q.zc_s1;
         d.trim = `RST_TRIM;
         d.mute = `RST_MUTE;
         d.cfg1 = `RST_CFG1; // RULE6 RULE7 RULE8
         d.cfg2 = `RST_CFG2; // RULE11
         for (int i = 0; i < 8; i++) begin
            d.last_tgt[i] = `RST_GAIN;
            d.applied[i] = `RST_GAIN;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      q <= d;
   end

   assign rdata_out = q.rdata;
   assign gain_out = q.applied;
   assign mute_out = q.mute_eff;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   sequence s_flush;
      q.pend_v[0] && chg[0] && mode == ZC_FLUSH;
   endsequence

   sequence s_discard;
      q.pend_v[0] && chg[0] && mode == ZC_DISCARD && !q.zc_s2[0] && q.timer[0] < limit;
   endsequence

   sequence s_kept_old;
      gain_out[0] == $past(gain_out[0]) && q.pend[0] == $past(tgt[0]) && q.timer[0] == 24'h000000;
   endsequence

   sequence s_pin_active;
      q.cfg1[`CFG1_PIN_EN] && q.pin_sync[1] == q.cfg1[`CFG1_PIN_POL];
   endsequence

   sequence s_expire;
      q.pend_v[0] && q.timer[0] == limit && !chg[0];
   endsequence

   sequence s_zc_hit;
      q.pend_v[0] && q.zc_s2[0] && !chg[0];
   endsequence

   sequence s_new_pend;
      chg[0] && (mode == ZC_DISCARD || mode == ZC_FLUSH);
   endsequence

   a_clamp_high: assert property (gain_out[3] <= `GAIN_MAX) // RULE3
      else $error("Channel gain above the top of the span.");

   a_clamp_low: assert property (gain_out[3] >= `GAIN_MIN) // RULE3
      else $error("Channel gain below the bottom of the span.");

   a_mute_bit: assert property (q.mute[2] |=> mute_out[2]) // RULE5
      else $error("Set mute bit did not mute its channel.");

   a_pin_ignored: assert property (!q.cfg1[`CFG1_PIN_EN] && q.mute == 8'h00 |=> mute_out == 8'h00) // RULE6
      else $error("Disabled mute pin still muted a channel.");

   a_pin_level: assert property (s_pin_active |=> mute_out == 8'hff) // RULE7
      else $error("Active mute pin did not mute all channels.");

   a_link_mute: assert property (q.cfg1[0] |=> mute_out[1] == mute_out[0]) // RULE8
      else $error("Linked pair mute differs.");

   a_link_target: assert property (q.cfg1[1] |-> tgt[3] == tgt[2]) // RULE9
      else $error("Linked pair targets differ.");

   a_unlinked_mute: assert property (!q.cfg1[2] |=> mute_out[5] == ($past(q.mute[5]) | $past(pin_act))) // RULE10
      else $error("Unlinked channel did not follow its own mute bit.");

   a_mode_now: assert property (mode == ZC_NOW && chg[0] |=> gain_out[0] == $past(tgt[0])) // RULE13
      else $error("Immediate mode change was not applied next cycle.");

   a_flush_old: assert property (s_flush |=> gain_out[0] == $past(q.pend[0]) && q.pend_v[0]) // RULE13
      else $error("Superseded change was not flushed.");

   a_discard_old: assert property (s_discard |=> s_kept_old) // RULE13 RULE15
      else $error("Superseded change was not discarded.");

   a_zc_apply: assert property (s_zc_hit |=> !q.pend_v[0] && gain_out[0] == $past(q.pend[0])) // RULE13
      else $error("Pending change not applied on a zero crossing.");

   a_timer_restart: assert property (s_new_pend |=> q.pend_v[0] && q.timer[0] == 24'h000000) // RULE15
      else $error("Accepted change did not restart the time-out count.");

   a_time_out: assert property (s_expire |=> !q.pend_v[0] && gain_out[0] == $past(q.pend[0])) // RULE2
      else $error("Pending change not applied at time-out.");

   a_gain_hold: assert property (!q.pend_v[0] && !chg[0] |=> $stable(gain_out[0])) // RULE2
      else $error("Gain changed with nothing pending.");

   a_trim_write: assert property (wr_en_in && addr_in == `ADDR_TRIM |=> q.trim == $past(wdata_in)) // RULE1
      else $error("Trim write did not land.");

   a_reset_cfg: assert property ($rose(rst_n_in) |-> q.cfg2 == `RST_CFG2 && q.cfg1 == `RST_CFG1) // RULE11
      else $error("Configuration reset values wrong.");
endmodule
`default_nettype wire

// ===== rtl/volume_mute_regs.svh
// Register offsets, field positions, reset values and timing figures of the volume and mute control block.
`ifndef VOLUME_MUTE_REGS_SVH
`define VOLUME_MUTE_REGS_SVH
`define ADDR_TRIM 8'h09
`define ADDR_MUTE 8'h0a
`define ADDR_CFG1 8'h0b
`define ADDR_CFG2 8'h0c
`define RST_TRIM 8'h00
`define RST_MUTE 8'h00
`define RST_CFG1 6'h20
`define RST_CFG2 5'h0d
`define RST_GAIN 9'h1a4
`define CFG1_PIN_EN 5
`define CFG1_PIN_POL 4
`define CFG2_TO_MSB 4
`define CFG2_TO_LSB 2
`define CFG2_MODE_MSB 1
`define GAIN_MIN 9'h024
`define GAIN_MAX 9'h1fc
`define CLK_PERIOD_NS 10
`define NS_PER_MS 1000000
`define TO_MS_0 5
`define TO_MS_1 10
`define TO_MS_2 15
`define TO_MS_3 18
`define TO_MS_4 20
`define TO_MS_5 30
`define TO_MS_6 40
`define TO_MS_7 50
`endif

// ===== verif/tb_top.sv
// Self-checking bench for the volume and mute control block.
`include "volume_mute_regs.svh"
`default_nettype none
module tb_top import vol_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 0, rst_n_in = 0, wr_en_in = 0, rd_en_in = 0, mute_pin_in = 1;
   logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, zero_cross_in = 8'h00, rdata_out, mute_out, rv;
   logic [7:0][7:0] vol_code_in = {8{8'hd2}};
   logic [7:0][8:0] gain_out;
   logic [8:0] prev;
   logic [7:0] tv [0:4] = '{8'hd2, 8'hfe, 8'hff, 8'h00, 8'h12};
   logic tt [0:4] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
   logic [8:0] tg [0:4] = '{9'h1a5, 9'h1fc, 9'h1fc, 9'h024, 9'h025};
   int ms [0:7] = '{5, 10, 15, 18, 20, 30, 40, 50};
   int failures = 0, num_checks = 0;
   volume_mute_config_regs #(.CYC_PER_MS(10)) i_volume_mute_config_regs (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .addr_in(addr_in), .wdata_in(wdata_in), .vol_code_in(vol_code_in),
      .zero_cross_in(zero_cross_in), .mute_pin_in(mute_pin_in), .rdata_out(rdata_out), .gain_out(gain_out),
      .mute_out(mute_out));
   initial begin
      forever #5 clk_in = ~clk_in;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      cyc(1);
      wr_en_in = 1;
      addr_in = a;
      wdata_in = d;
      cyc(1);
      wr_en_in = 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      cyc(1);
      rd_en_in = 1;
      addr_in = a;
      cyc(1);
      rd_en_in = 0;
      chk("rdata", {1'b0, rdata_out}, {1'b0, exp});
   endtask
   task automatic summarize();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      cyc(16);
      rst_n_in = 1;
      rd(`ADDR_TRIM, 8'h00);
      rd(`ADDR_MUTE, 8'h00);
      rd(`ADDR_CFG1, 8'h20);
      rd(`ADDR_CFG2, 8'h0d);
      rd(8'h0d, 8'h00);
      chk("gain0", gain_out[0], `RST_GAIN);
      chk("mute", {1'b0, mute_out}, 9'h000);
      wr(`ADDR_CFG2, 8'h0c);
      for (int i = 0; i < 5; i++) begin
         vol_code_in[0] = tv[i];
         wr(`ADDR_TRIM, {7'h00, tt[i]});
         cyc(3);
         chk("gain0", gain_out[0], tg[i]);
      end
      wr(`ADDR_MUTE, 8'h01);
      cyc(2);
      chk("mute", {1'b0, mute_out}, 9'h001);
      mute_pin_in = 0;
      cyc(4);
      chk("mute", {1'b0, mute_out}, 9'h0ff);
      wr(`ADDR_CFG1, 8'h30);
      cyc(2);
      chk("mute", {1'b0, mute_out}, 9'h001);
      mute_pin_in = 1;
      cyc(4);
      chk("mute", {1'b0, mute_out}, 9'h0ff);
      wr(`ADDR_CFG1, 8'h10);
      cyc(2);
      chk("mute", {1'b0, mute_out}, 9'h001);
      vol_code_in[0] = 8'hd2;
      vol_code_in[1] = 8'h40;
      wr(`ADDR_TRIM, 8'h00);
      wr(`ADDR_MUTE, 8'h55);
      wr(`ADDR_CFG1, 8'h0f);
      cyc(3);
      chk("mute", {1'b0, mute_out}, 9'h0ff);
      chk("gain1", gain_out[1], 9'h1a4);
      wr(`ADDR_CFG1, 8'h0a);
      cyc(3);
      chk("mute", {1'b0, mute_out}, 9'h0dd);
      chk("gain1", gain_out[1], 9'h080);
      prev = 9'h1a4;
      for (int i = 0; i < 8; i++) begin
         wr(`ADDR_CFG2, {3'h0, i[2:0], 2'b01});
         vol_code_in[0] = 8'h80 + 8'(i);
         cyc(ms[i] * 10);
         chk("gain_wait", gain_out[0], prev);
         cyc(1);
         prev = {vol_code_in[0], 1'b0};
         chk("gain_timeout", gain_out[0], prev);
      end
      wr(`ADDR_CFG2, 8'h01);
      wr(`ADDR_TRIM, 8'h01);
      cyc(5);
      chk("trim_wait", gain_out[0], prev);
      zero_cross_in = 8'h01;
      cyc(1);
      zero_cross_in = 8'h00;
      cyc(5);
      chk("trim_zc", gain_out[0], prev | 9'h001);
      vol_code_in[0] = 8'h90;
      cyc(5);
      vol_code_in[0] = 8'h91;
      cyc(5);
      chk("discard", gain_out[0], 9'h10f);
      zero_cross_in = 8'h01;
      cyc(1);
      zero_cross_in = 8'h00;
      cyc(5);
      chk("discard_zc", gain_out[0], 9'h123);
      wr(`ADDR_CFG2, 8'h02);
      vol_code_in[0] = 8'ha0;
      cyc(5);
      chk("flush_wait", gain_out[0], 9'h123);
      vol_code_in[0] = 8'ha1;
      cyc(3);
      chk("flush_old", gain_out[0], 9'h141);
      cyc(47);
      chk("flush_hold", gain_out[0], 9'h141);
      cyc(1);
      chk("flush_new", gain_out[0], 9'h143);
      wr(`ADDR_CFG2, 8'h03);
      vol_code_in[0] = 8'hb0;
      cyc(1);
      chk("reserved_now", gain_out[0], 9'h161);
      rst_n_in = 0;
      cyc(2);
      rst_n_in = 1;
      cyc(1);
      chk("mute_after_reset", {1'b0, mute_out}, 9'h000);
      chk("gain_after_reset", gain_out[0], `RST_GAIN);
      rd(`ADDR_TRIM, 8'h00);
      rd(`ADDR_MUTE, 8'h00);
      rd(`ADDR_CFG1, 8'h20);
      rd(`ADDR_CFG2, 8'h0d);
      summarize();
   end
   initial begin
      repeat (20000) @(posedge clk_in);
      failures++;
      summarize();
   end
endmodule
`default_nettype wire
